// ==== rtl/bcd_correct.sv ====
// Purpose: Decimal conversion stage after the binary adder.
// Assumes: Input is the carry or borrow bit above the binary nibble.
// Notes: Results outside the valid ranges come out at ten or more.
`timescale 1ns/1ps
module bcd_correct (
  input wire logic i_sub,
  input wire logic [4:0] i_bin,
  output logic [3:0] o_res,
  output logic o_carry
);

  logic [4:0] over_idx;

  // Map the binary pair onto a decimal digit and carry.
  always_comb begin
    over_idx = 5'h00;
    o_carry = 1'b1;
    o_res = i_bin[3:0];
    if (!i_sub) begin
      if (i_bin <= {1'b0, nibble_alu_pkg::DEC_LIMIT}) begin
        o_carry = 1'b0;
      end else if (i_bin <= nibble_alu_pkg::DEC_ADD_TOP) begin
        o_res = 4'(i_bin - nibble_alu_pkg::DEC_TEN);
      end else begin
        over_idx = i_bin - nibble_alu_pkg::DEC_ADD_OFFSET;
        o_res = nibble_alu_pkg::DEC_ADD_OVER[{over_idx[3:0], 2'b00} +: 4];
      end
    end else begin
      if (!i_bin[4] && i_bin[3:0] <= nibble_alu_pkg::DEC_LIMIT) begin
        o_carry = 1'b0;
      end else if (i_bin[4] && i_bin[3:0] >= nibble_alu_pkg::DEC_SUB_FIX) begin
        o_res = i_bin[3:0] - nibble_alu_pkg::DEC_SUB_FIX;
      end else begin
        // Borrowed values wrap past the unborrowed ones in the table.
        over_idx = i_bin - nibble_alu_pkg::DEC_TEN;
        o_res = nibble_alu_pkg::DEC_SUB_OVER[{over_idx[3:0], 2'b00} +: 4];
      end
    end
  end

endmodule // bcd_correct

// ==== rtl/nibble_alu.sv ====
// Purpose: Nibble ALU with binary and decimal add and subtract,
//   logic, rotation, bit tests and compares that decide a skip.
// Assumes: The sequencer drives one request at a time and gives
//   operand nibbles already read from register or memory.
// Notes: Flags are one store shared with the status word port.
//
// Functional notes
// - Latch both operands before any computing.
// - Operands: register/memory nibble, memory or immediate.
// - Rotation uses only the first operand.
// - Store result at first operand address.
// - Compares only decide a skip; bit tests also clear a flag.
// - Logic ops keep carry and zero untouched.
// - Bit test clears the compare-no-store flag.
// - Add, add-carry, subtract, subtract-borrow supported.
// - Decimal flag picks mode; compare flag blocks arithmetic store.
// - Binary carry on result above 15 or below 0.
// - Binary stored: zero set when nibble is zero.
// - Compare flag on: no store, carry still updated.
// - Compare flag on: zero kept, nonzero clears it.
// - Decimal carry on result above 9 or below 0.
// - Decimal zero follows the corrected result.
// - Decimal: binary result, then correction stage.
// - Out of range decimal: carry, result ten up.
// - Decimal add valid for sums zero to nineteen.
// - Decimal borrow pairs map to minus ten..one.
// - Carry feeds chained ops; rotation moves carry.
// - Flags are the program status word itself.
`timescale 1ns/1ps
module nibble_alu (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire nibble_alu_pkg::alu_req_s i_req,
  input wire logic i_psw_wr,
  input wire nibble_alu_pkg::program_status_word_s i_psw,
  output nibble_alu_pkg::wb_s o_wb,
  output logic o_skip,
  output logic o_done,
  output logic o_busy,
  output nibble_alu_pkg::program_status_word_s o_program_status_word
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_e;

  typedef struct packed {
    state_e st;
    nibble_alu_pkg::alu_op_e op;
    logic first_in_mem;
    logic [nibble_alu_pkg::ADDR_W-1:0] first_addr;
    logic [3:0] opnd_a;
    logic [3:0] opnd_b;
    nibble_alu_pkg::program_status_word_s psw;
    nibble_alu_pkg::wb_s wb;
    logic skip;
    logic done;
    logic busy;
  } core_s;

  localparam core_s CORE_RESET = '{
    st: ST_IDLE,
    op: nibble_alu_pkg::OP_ADD,
    opnd_a: nibble_alu_pkg::NIBBLE_RESET,
    opnd_b: nibble_alu_pkg::NIBBLE_RESET,
    psw: nibble_alu_pkg::PSW_RESET,
    wb: '0,
    default: '0
  };

  core_s core_reg;
  core_s core_next;

  logic is_sub;
  logic carry_in;
  logic [4:0] bin_sum;
  logic [3:0] dec_res;
  logic dec_carry;
  logic [3:0] arith_res;
  logic arith_carry;
  logic arith_zero;

  // Carry-in and direction come from the latched instruction.
  always_comb begin
    is_sub = (core_reg.op == nibble_alu_pkg::OP_SUB) ||
      (core_reg.op == nibble_alu_pkg::OP_DIFFERENCE_WITH_BORROW);
    carry_in = core_reg.psw.carry_flag &&
      ((core_reg.op == nibble_alu_pkg::OP_SUM_WITH_CARRY_IN) ||
      (core_reg.op == nibble_alu_pkg::OP_DIFFERENCE_WITH_BORROW));
  end

  // The binary result always comes first; bit 4 is carry or borrow.
  always_comb begin
    if (is_sub) begin
      bin_sum = {1'b0, core_reg.opnd_a} - {1'b0, core_reg.opnd_b} -
        {4'h0, carry_in};
    end else begin
      bin_sum = {1'b0, core_reg.opnd_a} + {1'b0, core_reg.opnd_b} +
        {4'h0, carry_in};
    end
  end

  // Decimal correction stage, fed by the binary pair.
  bcd_correct u_bcd_correct (
    .i_sub(is_sub),
    .i_bin(bin_sum),
    .o_res(dec_res),
    .o_carry(dec_carry)
  );

  // Mode select and the zero flag policy of the compare flag.
  always_comb begin
    if (core_reg.psw.decimal_flag) begin
      arith_res = dec_res;
      arith_carry = dec_carry;
    end else begin
      arith_res = bin_sum[3:0];
      arith_carry = bin_sum[4];
    end
    if (core_reg.psw.compare_no_store_flag) begin
      // Chained compares keep a zero from earlier nibbles alive.
      arith_zero = (arith_res == nibble_alu_pkg::ZERO_NIBBLE) &&
        core_reg.psw.zero_flag;
    end else begin
      arith_zero = (arith_res == nibble_alu_pkg::ZERO_NIBBLE);
    end
  end

  // Sequencing, write-back, skip decision and flag updates.
  always_comb begin
    core_next = core_reg;
    core_next.wb.en = 1'b0;
    core_next.skip = 1'b0;
    core_next.done = 1'b0;
    unique case (core_reg.st)
      ST_IDLE: begin
        // Direct flag writes are taken only between instructions.
        if (i_psw_wr) begin
          core_next.psw = i_psw;
        end
        if (i_start) begin
          core_next.st = ST_EXEC;
          core_next.busy = 1'b1;
          core_next.op = i_req.op;
          core_next.first_in_mem = i_req.first_in_mem;
          core_next.first_addr = i_req.first_addr;
          core_next.opnd_a = i_req.first_data;
          if (i_req.op != nibble_alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY) begin
            if (i_req.second_is_imm) begin
              core_next.opnd_b = i_req.immediate_nibble_operand;
            end else begin
              core_next.opnd_b = i_req.second_mem_data;
            end
          end else begin
            core_next.opnd_b = core_reg.opnd_b;
          end
        end
      end
      ST_EXEC: begin
        core_next.st = ST_IDLE;
        core_next.busy = 1'b0;
        core_next.done = 1'b1;
        core_next.wb.addr = core_reg.first_addr;
        core_next.wb.to_mem = core_reg.first_in_mem;
        case (core_reg.op)
          nibble_alu_pkg::OP_ADD,
          nibble_alu_pkg::OP_SUM_WITH_CARRY_IN,
          nibble_alu_pkg::OP_SUB,
          nibble_alu_pkg::OP_DIFFERENCE_WITH_BORROW: begin
            // The result is kept on the bus even when not stored.
            core_next.wb.data = arith_res;
            core_next.wb.en =
              !core_reg.psw.compare_no_store_flag;
            core_next.psw.carry_flag = arith_carry;
            core_next.psw.zero_flag = arith_zero;
          end
          nibble_alu_pkg::OP_OR: begin
            core_next.wb.data = core_reg.opnd_a | core_reg.opnd_b;
            core_next.wb.en = 1'b1;
          end
          nibble_alu_pkg::OP_AND: begin
            core_next.wb.data = core_reg.opnd_a & core_reg.opnd_b;
            core_next.wb.en = 1'b1;
          end
          nibble_alu_pkg::OP_XOR: begin
            core_next.wb.data = core_reg.opnd_a ^ core_reg.opnd_b;
            core_next.wb.en = 1'b1;
          end
          nibble_alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
            core_next.wb.data = {core_reg.psw.carry_flag,
              core_reg.opnd_a[3:1]};
            core_next.psw.carry_flag = core_reg.opnd_a[0];
            core_next.wb.en = 1'b1;
          end
          nibble_alu_pkg::OP_TEST_ONES: begin
            core_next.skip = ((core_reg.opnd_a & core_reg.opnd_b) ==
              core_reg.opnd_b);
            core_next.psw.compare_no_store_flag = 1'b0;
          end
          nibble_alu_pkg::OP_TEST_ZEROS: begin
            core_next.skip = ((core_reg.opnd_a & core_reg.opnd_b) ==
              nibble_alu_pkg::ZERO_NIBBLE);
            core_next.psw.compare_no_store_flag = 1'b0;
          end
          nibble_alu_pkg::OP_SKIP_EQ: begin
            core_next.skip = (core_reg.opnd_a == core_reg.opnd_b);
          end
          nibble_alu_pkg::OP_SKIP_NE: begin
            core_next.skip = (core_reg.opnd_a != core_reg.opnd_b);
          end
          nibble_alu_pkg::OP_SKIP_GE: begin
            core_next.skip = (core_reg.opnd_a >= core_reg.opnd_b);
          end
          nibble_alu_pkg::OP_SKIP_LT: begin
            core_next.skip = (core_reg.opnd_a < core_reg.opnd_b);
          end
          default: begin
            // Unused opcodes finish without any effect.
            core_next.skip = 1'b0;
          end
        endcase
      end
      default: begin
        core_next = CORE_RESET;
      end
    endcase
  end

  // The whole state sits in one register.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_reg <= CORE_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  // Every output is a field of the state register.
  assign o_wb = core_reg.wb;
  assign o_skip = core_reg.skip;
  assign o_done = core_reg.done;
  assign o_busy = core_reg.busy;
  assign o_program_status_word = core_reg.psw;

  logic last_arith;
  logic last_logic;
  logic last_test;

  // Classes of the instruction that just finished, for the checks.
  always_comb begin
    last_arith = (core_reg.op == nibble_alu_pkg::OP_ADD) ||
      (core_reg.op == nibble_alu_pkg::OP_SUM_WITH_CARRY_IN) || is_sub;
    last_logic = (core_reg.op == nibble_alu_pkg::OP_OR) ||
      (core_reg.op == nibble_alu_pkg::OP_AND) ||
      (core_reg.op == nibble_alu_pkg::OP_XOR);
    last_test = (core_reg.op == nibble_alu_pkg::OP_TEST_ONES) ||
      (core_reg.op == nibble_alu_pkg::OP_TEST_ZEROS);
  end

  a_latch_then_done: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_start && !o_busy) |=> o_busy ##1 (o_done && !o_busy))
    else $error("Request did not finish two cycles after acceptance.");

  a_logic_keeps_flags: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && last_logic) |->
      ($stable(o_program_status_word.carry_flag) &&
      $stable(o_program_status_word.zero_flag) && o_wb.en))
    else $error("Logic operation changed flags or did not store.");

  a_test_clears_cmp: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && last_test) |->
      (!o_program_status_word.compare_no_store_flag && !o_wb.en))
    else $error("Bit test left the compare flag set or stored.");

  a_store_gate: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && last_arith) |->
      (o_wb.en == !o_program_status_word.compare_no_store_flag) &&
      (o_wb.addr == core_reg.first_addr))
    else $error("Arithmetic store does not follow the compare flag.");

  a_rotate_carry: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && core_reg.op ==
      nibble_alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY) |->
      (o_wb.data == {$past(o_program_status_word.carry_flag),
      core_reg.opnd_a[3:1]}) &&
      (o_program_status_word.carry_flag == core_reg.opnd_a[0]))
    else $error("Rotation moved carry or bit zero wrongly.");

  a_binary_add_carry: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && core_reg.op == nibble_alu_pkg::OP_ADD &&
      !o_program_status_word.decimal_flag) |->
      (o_program_status_word.carry_flag ==
      (({1'b0, core_reg.opnd_a} + {1'b0, core_reg.opnd_b}) >
      nibble_alu_pkg::BIN_LIMIT)))
    else $error("Binary add carry does not match the true sum.");

  a_zero_held_cmp: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && last_arith &&
      o_program_status_word.compare_no_store_flag) |->
      (o_program_status_word.zero_flag ==
      ((o_wb.data == nibble_alu_pkg::ZERO_NIBBLE) &&
      $past(o_program_status_word.zero_flag))))
    else $error("Zero flag broke the compare chaining policy.");

  a_decimal_over: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && last_arith && o_program_status_word.decimal_flag &&
      o_wb.data > nibble_alu_pkg::DEC_LIMIT) |->
      o_program_status_word.carry_flag)
    else $error("Decimal result above nine without carry.");

  a_decimal_add_fix: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && core_reg.op == nibble_alu_pkg::OP_ADD &&
      o_program_status_word.decimal_flag &&
      (({1'b0, core_reg.opnd_a} + {1'b0, core_reg.opnd_b}) >=
      nibble_alu_pkg::DEC_TEN) &&
      (({1'b0, core_reg.opnd_a} + {1'b0, core_reg.opnd_b}) <=
      nibble_alu_pkg::DEC_ADD_TOP)) |->
      (o_program_status_word.carry_flag &&
      (o_wb.data == 4'({1'b0, core_reg.opnd_a} + {1'b0, core_reg.opnd_b} -
      nibble_alu_pkg::DEC_TEN))))
    else $error("Decimal sum of ten to nineteen was not corrected.");

  a_rotate_keeps_flags: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && core_reg.op ==
      nibble_alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY) |->
      ($stable(o_program_status_word.zero_flag) &&
      $stable(o_program_status_word.compare_no_store_flag) && o_wb.en))
    else $error("Rotation changed other flags or did not store.");

  a_skip_equal: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_done && core_reg.op == nibble_alu_pkg::OP_SKIP_EQ) |->
      (o_skip == (core_reg.opnd_a == core_reg.opnd_b)) && !o_wb.en)
    else $error("Equality skip decision is wrong.");

  a_skip_pulse: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_skip || o_wb.en) |-> o_done)
    else $error("Skip or store outside a finishing cycle.");

endmodule // nibble_alu

// ==== rtl/nibble_alu_pkg.sv ====
// Purpose: Shared types and constants for the nibble ALU datapath.
// Assumes: One core clock; the sequencer supplies operand nibbles.
// Notes: Flag layout and reset values are local choices.
package nibble_alu_pkg;

  // Address width of the general register and data memory space.
  localparam int ADDR_W = 7;

  // Instruction classes handled by the datapath.
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUM_WITH_CARRY_IN = 4'h1,
    OP_SUB = 4'h2,
    OP_DIFFERENCE_WITH_BORROW = 4'h3,
    OP_OR = 4'h4,
    OP_AND = 4'h5,
    OP_XOR = 4'h6,
    OP_ROTATE_RIGHT_THROUGH_CARRY = 4'h7,
    OP_TEST_ONES = 4'h8,
    OP_TEST_ZEROS = 4'h9,
    OP_SKIP_EQ = 4'ha,
    OP_SKIP_NE = 4'hb,
    OP_SKIP_GE = 4'hc,
    OP_SKIP_LT = 4'hd
  } alu_op_e;

  // The four status flags, shared with the program status word.
  typedef struct packed {
    logic compare_no_store_flag;
    logic carry_flag;
    logic zero_flag;
    logic decimal_flag;
  } program_status_word_s;

  // One instruction as handed over by the sequencer.
  typedef struct packed {
    alu_op_e op;
    logic first_in_mem;
    logic [ADDR_W-1:0] first_addr;
    logic [3:0] first_data;
    logic second_is_imm;
    logic [3:0] second_mem_data;
    logic [3:0] immediate_nibble_operand;
  } alu_req_s;

  // Write-back toward the general register or data memory.
  typedef struct packed {
    logic en;
    logic to_mem;
    logic [ADDR_W-1:0] addr;
    logic [3:0] data;
  } wb_s;

  // Values after reset.
  localparam program_status_word_s PSW_RESET = 4'h0;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;

  // Limits of the binary and decimal ranges.
  localparam logic [4:0] BIN_LIMIT = 5'h0f;
  localparam logic [3:0] DEC_LIMIT = 4'h9;
  localparam logic [4:0] DEC_TEN = 5'h0a;
  localparam logic [4:0] DEC_ADD_TOP = 5'h13;
  localparam logic [4:0] DEC_ADD_OFFSET = 5'h14;
  localparam logic [3:0] DEC_SUB_FIX = 4'h6;
  localparam logic [3:0] ZERO_NIBBLE = 4'h0;

  // Out-of-range decimal results, one nibble per step past the range.
  localparam logic [47:0] DEC_ADD_OVER = 48'hdcba_dcfe_dcfe;
  localparam logic [47:0] DEC_SUB_OVER = 48'hfedc_fedc_fedc;

endpackage

// ==== verification/nibble_alu_tb_top.sv ====
// Purpose: Self-checking bench for the nibble ALU datapath.
// Assumes: One request at a time, answered two cycles after it is taken.
// Notes: Expected results and flags come from an integer model here.
`timescale 1ns/1ps
module nibble_alu_tb_top;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_start = 1'b0;
  logic i_psw_wr = 1'b0;
  nibble_alu_pkg::alu_req_s i_req = '0;
  nibble_alu_pkg::program_status_word_s i_psw = '0;
  nibble_alu_pkg::wb_s o_wb;
  logic o_skip;
  logic o_done;
  logic o_busy;
  nibble_alu_pkg::program_status_word_s o_program_status_word;
  nibble_alu_pkg::program_status_word_s m_psw = '0;
  logic pa_mem = 1'b0;
  logic [nibble_alu_pkg::ADDR_W-1:0] pa_addr = '0;
  logic [3:0] pa_data;
  logic [31:0] seed = 32'hc793_fcc5;
  int errors = 0;
  int cmp_count = 0;

  // Core clock with a 4 ns period.
  always #2 i_clk = ~i_clk;

  nibble_alu i_nibble_alu (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(i_start),
    .i_req(i_req),
    .i_psw_wr(i_psw_wr),
    .i_psw(i_psw),
    .o_wb(o_wb),
    .o_skip(o_skip),
    .o_done(o_done),
    .o_busy(o_busy),
    .o_program_status_word(o_program_status_word)
  );

  operand_store i_operand_store (
    .i_clk(i_clk),
    .i_wb(o_wb),
    .i_mem(pa_mem),
    .i_addr(pa_addr),
    .o_data(pa_data)
  );

  // Xorshift source; a fixed start keeps every run the same.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_vec(input string nm, input logic [11:0] e,
      input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Predicts one instruction, issues it, offers ignored junk while busy,
  // then compares every result in the cycle the answer stands.
  task automatic run(input nibble_alu_pkg::alu_op_e op, input logic fim,
      input logic [nibble_alu_pkg::ADDR_W-1:0] ad, input logic [3:0] a,
      input logic si, input logic [3:0] bm, input logic [3:0] im,
      input logic wr, input logic [3:0] wv);
    int o;
    int ia;
    int ib;
    int s;
    int r;
    int v;
    logic c;
    logic en;
    logic sk;
    logic [31:0] t;
    o = op;
    ia = a;
    ib = si ? im : bm;
    r = 0;
    en = 1'b0;
    sk = 1'b0;
    if (wr) begin
      m_psw = wv;
    end
    c = m_psw.carry_flag;
    if (o < 4) begin
      v = (o % 2) * c;
      s = (o < 2) ? ia + ib + v : ia - ib - v;
      if (!m_psw.decimal_flag) begin
        r = s & 15;
        c = (s > 15) || (s < 0);
      end else if (s >= 0 && s < 10) begin
        r = s;
        c = 1'b0;
      end else if (o < 2 && s < 20) begin
        r = s - 10;
        c = 1'b1;
      end else if (o >= 2 && s < 0 && s >= -10) begin
        r = s + 10;
        c = 1'b1;
      end else begin
        // Differences of ten to fifteen land here as well as deep borrows.
        c = 1'b1;
        v = s & 31;
        r = (o >= 2) ? 12 + (v - 10) % 4 :
            (v < 28) ? 12 + (v - 18) % 4 : v - 18;
      end
      m_psw.zero_flag = m_psw.compare_no_store_flag ?
          (m_psw.zero_flag && r == 0) : (r == 0);
      m_psw.carry_flag = c;
      en = !m_psw.compare_no_store_flag;
    end else if (o < 7) begin
      r = (o == 4) ? (ia | ib) : (o == 5) ? (ia & ib) : (ia ^ ib);
      en = 1'b1;
    end else if (o == 7) begin
      r = c * 8 + ia / 2;
      m_psw.carry_flag = a[0];
      en = 1'b1;
    end else begin
      // Codes fourteen and fifteen finish with no skip and no flag change.
      case (o)
        8: sk = (ia & ib) == ib;
        9: sk = (ia & ib) == 0;
        10: sk = ia == ib;
        11: sk = ia != ib;
        12: sk = ia >= ib;
        13: sk = ia < ib;
        default: sk = 1'b0;
      endcase
      if (o < 10) begin
        m_psw.compare_no_store_flag = 1'b0;
      end
    end
    @(posedge i_clk);
    #1;
    i_start = 1'b1;
    i_req = '{op, fim, ad, a, si, bm, im};
    i_psw_wr = wr;
    i_psw = wv;
    @(posedge i_clk);
    #1;
    chk_bit("busy", 1'b1, o_busy);
    chk_bit("done_early", 1'b0, o_done);
    // Requests and flag writes offered now must leave no trace.
    t = rnd();
    i_req = t[24:0];
    i_psw_wr = 1'b1;
    i_psw = t[28:25];
    @(posedge i_clk);
    #1;
    i_start = 1'b0;
    i_psw_wr = 1'b0;
    chk_bit("done", 1'b1, o_done);
    chk_bit("idle", 1'b0, o_busy);
    chk_bit("skip", sk, o_skip);
    chk_bit("wb_en", en, o_wb.en);
    if (o < 8) begin
      chk_vec("wb_data", 12'(r), {8'h00, o_wb.data});
    end
    if (en) begin
      chk_vec("wb_addr", {4'h0, fim, ad},
          {4'h0, o_wb.to_mem, o_wb.addr});
    end
    chk_vec("psw", {8'h00, m_psw},
        {8'h00, o_program_status_word});
  endtask

  // Main sequence: reset, every arithmetic case, random mix, reset again.
  initial begin
    logic [31:0] t;
    repeat (4) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    chk_vec("reset_psw", 12'h000, {8'h00, o_program_status_word});
    chk_bit("reset_done", 1'b0, o_done);
    for (int md = 0; md < 4; md++) begin
      for (int o = 0; o < 4; o++) begin
        for (int k = 0; k < 256; k++) begin
          t = rnd();
          run(nibble_alu_pkg::alu_op_e'(o), t[0], t[7:1],
              4'(k / 16), 1'b1, t[11:8], 4'(k), k == 0,
              {md[1], t[12], t[13], md[0]});
        end
      end
    end
    // The first operand comes from the store model, with flags rewritten at times.
    // All sixteen codes are drawn, so the two unused ones are seen too.
    for (int n = 0; n < 1500; n++) begin
      t = rnd();
      pa_mem = t[4];
      pa_addr = t[11:5];
      #1;
      run(nibble_alu_pkg::alu_op_e'(t[3:0]), pa_mem, pa_addr,
          pa_data, t[12], t[16:13], t[20:17], t[21] & t[22], t[26:23]);
    end
    run(nibble_alu_pkg::OP_ADD, 1'b0, 7'h01, 4'h1, 1'b1, 4'h0, 4'h2,
        1'b1, 4'hf);
    // A reset in mid-run must clear the write-back and flags at once.
    @(posedge i_clk);
    #1;
    i_reset_n = 1'b0;
    #1;
    chk_vec("reset_psw", 12'h000, {8'h00, o_program_status_word});
    chk_vec("reset_wb", 12'h000,
        {o_wb.to_mem, o_wb.addr, o_wb.data});
    chk_bit("reset_en", 1'b0, o_wb.en);
    m_psw = nibble_alu_pkg::PSW_RESET;
    @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    run(nibble_alu_pkg::OP_SUB, 1'b1, 7'h05, 4'h3, 1'b1, 4'h0, 4'h3,
        1'b0, 4'h0);
    conclude();
  end

  // About 17k cycles are needed; the limit leaves ample margin.
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule // nibble_alu_tb_top

// ==== verification/operand_store.sv ====
// Purpose: General register and data memory model behind the nibble ALU.
// Assumes: Write-backs land on the clock edge where en is high.
// Notes: A read of the location being written sees the new nibble.
`timescale 1ns/1ps
module operand_store (
  input wire logic i_clk,
  input wire nibble_alu_pkg::wb_s i_wb,
  input wire logic i_mem,
  input wire logic [nibble_alu_pkg::ADDR_W-1:0] i_addr,
  output logic [3:0] o_data
);
  logic [3:0] store [0:255];
  logic hit;

  // A fixed pattern keeps every location known from the start.
  initial begin
    for (int k = 0; k < 256; k++) begin
      store[k] = 4'(k * 7);
    end
  end

  // Forwarding spares the sequencer a stale read right after a store.
  assign hit = i_wb.en && ({i_wb.to_mem, i_wb.addr} == {i_mem, i_addr});
  assign o_data = hit ? i_wb.data : store[{i_mem, i_addr}];

  // The result lands at the place the first operand came from.
  always @(posedge i_clk) begin
    if (i_wb.en) begin
      store[{i_wb.to_mem, i_wb.addr}] <= i_wb.data;
    end
  end
endmodule // operand_store
